// File: dtc_timer.sv
// top of the dual 8-bit timer control block with an apb register slave
// assumes low_speed comes from system logic on pclk, fs_pin is asynchronous
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - lower clock select picks fc/2^11 or fs/2^3 by divider tap, fc/2^7, fc/2^5, fc/2^3, fs, fc/2, fc; 111 reserved.
// - clearing the lower run bit stops and clears the counter, setting it starts counting.
// - lower mode 000 is 8-bit timer, 011 is cascade, other codes reserved.
// - cascade needs lower mode 011, and the 16-bit mode then comes from the upper mode field.
// - in cascade the lower clock select drives the pair while the upper run and flip-flop bits govern it.
// - pulse-width registers may change while running only in 8-bit or 16-bit pwm modes; writes in other modes are not blocked.
// - lower control holds clock select 6-4, run 3, mode 2-0, bit 7 unused, all zero after reset.
// - upper control holds flip-flop 7, clock select 6-4, run 3, mode 2-0, all zero after reset.
// - upper period and pulse-width registers are read-write and reset to all ones.
// - each timer has a control register, a period register and a pulse-width register.
// - upper mode encodes timer, divider, 8-bit pwm, reserved, 16-bit timer, warm-up, 16-bit pwm.
// - in upper modes 1xx the upper count clock is the lower overflow whatever its own select.
module dtc_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dtc_pkg::addr_width-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fs_pin,
  input wire logic low_speed,
  output logic upper_timer_out,
  output logic irq
);
  // registers
  logic [6:0] lower_timer_control;
  logic [7:0] upper_timer_control;
  logic [7:0] lower_timer_period;
  logic [7:0] lower_timer_pulse_width;
  logic [7:0] upper_timer_period;
  logic [7:0] upper_timer_pulse_width;
  logic [dtc_pkg::int_count-1:0] int_status;
  logic [dtc_pkg::int_count-1:0] int_mask;
  logic divider_tap_select;
  logic upper_run_prev;

  // control fields
  wire [2:0] lower_clock_select = lower_timer_control[dtc_pkg::pos_clk_hi:dtc_pkg::pos_clk_lo];
  wire lower_run_bit = lower_timer_control[dtc_pkg::pos_run];
  wire [2:0] lower_mode_field = lower_timer_control[dtc_pkg::pos_mode_hi:0];
  wire [2:0] upper_clock_select = upper_timer_control[dtc_pkg::pos_clk_hi:dtc_pkg::pos_clk_lo];
  wire upper_run_bit = upper_timer_control[dtc_pkg::pos_run];
  wire [2:0] upper_mode_field = upper_timer_control[dtc_pkg::pos_mode_hi:0];
  wire upper_output_flipflop_ctl = upper_timer_control[dtc_pkg::pos_ff];

  // apb decode
  wire [5:0] word_index = paddr[dtc_pkg::addr_width-1:2];
  wire aligned = (paddr[1:0] == 2'h0);
  wire hit_lower_control = aligned && (word_index == dtc_pkg::idx_lower_control);
  wire hit_upper_control = aligned && (word_index == dtc_pkg::idx_upper_control);
  wire hit_lower_period = aligned && (word_index == dtc_pkg::idx_lower_period);
  wire hit_lower_pulse = aligned && (word_index == dtc_pkg::idx_lower_pulse_width);
  wire hit_upper_period = aligned && (word_index == dtc_pkg::idx_upper_period);
  wire hit_upper_pulse = aligned && (word_index == dtc_pkg::idx_upper_pulse_width);
  wire hit_int_status = aligned && (word_index == dtc_pkg::idx_int_status);
  wire hit_int_mask = aligned && (word_index == dtc_pkg::idx_int_mask);
  wire hit_count = aligned && (word_index == dtc_pkg::idx_count);
  wire hit_state = aligned && (word_index == dtc_pkg::idx_state);
  wire hit_config = aligned && (word_index == dtc_pkg::idx_config);
  wire mapped = hit_lower_control | hit_upper_control | hit_lower_period | hit_lower_pulse |
                hit_upper_period | hit_upper_pulse | hit_int_status | hit_int_mask |
                hit_count | hit_state | hit_config;
  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable;
  wire wr = access_phase & pwrite & mapped;

  // zero-wait slave; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access_phase & ~mapped;

  // prescaler taps
  dtc_tap_if taps ();

  dtc_prescaler prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .fs_pin(fs_pin),
    .taps(taps.source)
  );

  // tick selection per clock-select code, divider tap and power mode
  function automatic logic pick_tick(input logic [2:0] sel, input logic dv, input logic slow,
                                     input logic [dtc_pkg::tap_count-1:0] t);
    logic r;
    r = 1'b0;
    unique case (sel)
      dtc_pkg::clk_slow_tap: r = (dv | slow) ? t[dtc_pkg::tap_fs_div8] : t[dtc_pkg::tap_fc_div2048];
      dtc_pkg::clk_fc_div128: r = ~slow & t[dtc_pkg::tap_fc_div128];
      dtc_pkg::clk_fc_div32: r = ~slow & t[dtc_pkg::tap_fc_div32];
      dtc_pkg::clk_fc_div8: r = ~slow & t[dtc_pkg::tap_fc_div8];
      dtc_pkg::clk_fs: r = t[dtc_pkg::tap_fs];
      dtc_pkg::clk_fc_div2: r = ~slow & t[dtc_pkg::tap_fc_div2];
      dtc_pkg::clk_fc: r = t[dtc_pkg::tap_fc];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // taps that low-speed modes do not offer stay silent there
  wire lower_tick = pick_tick(lower_clock_select, divider_tap_select, low_speed, taps.tick);
  wire upper_own_tick = pick_tick(upper_clock_select, divider_tap_select, low_speed, taps.tick);

  // mode decode
  wire upper_wide = upper_mode_field[2];
  wire cascade = (lower_mode_field == dtc_pkg::mode_cascade) && upper_wide;
  wire lower_timer8 = (lower_mode_field == dtc_pkg::mode_timer8);
  wire upper_pwm8 = (upper_mode_field == dtc_pkg::mode_pwm8);
  wire upper_pwm16 = (upper_mode_field == dtc_pkg::mode_pwm16);
  wire upper_divider = (upper_mode_field == dtc_pkg::mode_divider8);
  wire upper_warmup = (upper_mode_field == dtc_pkg::mode_warmup);
  wire upper_timer16 = (upper_mode_field == dtc_pkg::mode_timer16);
  wire upper_narrow_count = ~upper_wide && ~upper_pwm8 &&
                            (upper_mode_field != dtc_pkg::mode_cascade);

  // in cascade the upper run bit governs both halves
  wire lower_run = cascade ? upper_run_bit : (lower_run_bit & lower_timer8);
  wire upper_run = upper_run_bit & (~upper_wide | cascade);

  logic [7:0] lower_count;
  logic [7:0] upper_count;
  logic lower_carry;
  logic upper_carry;

  // compare logic
  wire [15:0] count16 = {upper_count, lower_count};
  wire [15:0] period16 = {upper_timer_period, lower_timer_period};
  wire [15:0] pulse16 = {upper_timer_pulse_width, lower_timer_pulse_width};
  // warm-up matches the high byte when the low byte is all ones; the low byte runs free
  wire match16 = upper_warmup ? ((upper_count == upper_timer_period) && (&lower_count))
                              : (count16 == period16);
  // a stopped pair with period zero must not raise events
  wire hit16 = cascade && upper_run && lower_tick && (upper_timer16 || upper_warmup) && match16;
  wire lower_hit8 = ~cascade && lower_run && lower_tick && (lower_count == lower_timer_period);
  wire upper_hit8 = upper_narrow_count && upper_run && upper_own_tick &&
                    (upper_count == upper_timer_period);
  wire pwm8_hit = upper_pwm8 && upper_run && upper_own_tick && (upper_count == upper_timer_pulse_width);
  wire pwm16_hit = cascade && upper_pwm16 && lower_tick && (count16 == pulse16);
  wire pwm16_wrap = cascade && upper_pwm16 && upper_carry;
  wire pwm8_wrap = upper_pwm8 && upper_carry;

  // lower overflow clocks the upper half in 16-bit modes
  wire upper_tick = upper_wide ? (lower_carry | hit16) : upper_own_tick;
  wire upper_clear = upper_wide ? hit16 : upper_hit8;
  wire lower_clear = cascade ? hit16 : lower_hit8;

  dtc_counter8 #(
    .width(8)
  ) lower_counter (
    .pclk(pclk),
    .presetn(presetn),
    .run(lower_run),
    .tick(lower_tick),
    .clear(lower_clear),
    .count(lower_count),
    .carry(lower_carry)
  );

  dtc_counter8 #(
    .width(8)
  ) upper_counter (
    .pclk(pclk),
    .presetn(presetn),
    .run(upper_run),
    .tick(upper_tick),
    .clear(upper_clear),
    .count(upper_count),
    .carry(upper_carry)
  );

  // interrupt events
  wire lower_event = lower_hit8;
  wire upper_event = upper_hit8 | hit16 | pwm8_wrap | pwm16_wrap;
  wire [dtc_pkg::int_count-1:0] int_set = {upper_event, lower_event};
  wire [dtc_pkg::int_count-1:0] int_clear = (wr && hit_int_status) ?
                                            pwdata[dtc_pkg::int_count-1:0] : '0;
  assign irq = |(int_status & int_mask);

  // read mux
  logic [31:0] read_value;
  always_comb
  begin
    read_value = 32'h0000_0000;
    if (hit_lower_control)
      read_value = {25'h0, lower_timer_control};
    else if (hit_upper_control)
      read_value = {24'h0, upper_timer_control};
    else if (hit_lower_period)
      read_value = {24'h0, lower_timer_period};
    else if (hit_lower_pulse)
      read_value = {24'h0, lower_timer_pulse_width};
    else if (hit_upper_period)
      read_value = {24'h0, upper_timer_period};
    else if (hit_upper_pulse)
      read_value = {24'h0, upper_timer_pulse_width};
    else if (hit_int_status)
      read_value = {30'h0, int_status};
    else if (hit_int_mask)
      read_value = {30'h0, int_mask};
    else if (hit_count)
      read_value = {16'h0, count16};
    else if (hit_state)
      read_value = {28'h0, cascade, upper_run, lower_run, upper_timer_out};
    else if (hit_config)
      read_value = {31'h0, divider_tap_select};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_phase && !pwrite)
      prdata <= read_value;
  end

  // register writes; no write is blocked while running, software keeps that discipline
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lower_timer_control <= dtc_pkg::rst_lower_control;
      upper_timer_control <= dtc_pkg::rst_upper_control;
      lower_timer_period <= dtc_pkg::rst_period;
      lower_timer_pulse_width <= dtc_pkg::rst_pulse_width;
      upper_timer_period <= dtc_pkg::rst_period;
      upper_timer_pulse_width <= dtc_pkg::rst_pulse_width;
      int_mask <= '0;
      divider_tap_select <= 1'b0;
    end
    else if (wr)
    begin
      if (hit_lower_control)
        lower_timer_control <= pwdata[6:0];
      if (hit_upper_control)
        upper_timer_control <= pwdata[7:0];
      if (hit_lower_period)
        lower_timer_period <= pwdata[7:0];
      if (hit_lower_pulse)
        lower_timer_pulse_width <= pwdata[7:0];
      if (hit_upper_period)
        upper_timer_period <= pwdata[7:0];
      if (hit_upper_pulse)
        upper_timer_pulse_width <= pwdata[7:0];
      if (hit_int_mask)
        int_mask <= pwdata[dtc_pkg::int_count-1:0];
      if (hit_config)
        divider_tap_select <= pwdata[0];
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_status <= '0;
    else
      int_status <= (int_status & ~int_clear) | int_set;
  end

  // output flip-flop follows the upper flip-flop bit, also in cascade
  wire upper_start = upper_run && !upper_run_prev;
  logic next_out;
  always_comb
  begin
    next_out = upper_timer_out;
    if (upper_start)
      next_out = upper_output_flipflop_ctl;
    else if (upper_run && upper_divider && upper_hit8)
      next_out = ~upper_timer_out;
    else if (upper_run && (pwm8_hit || pwm16_hit))
      next_out = ~upper_output_flipflop_ctl;
    else if (upper_run && (pwm8_wrap || pwm16_wrap))
      next_out = upper_output_flipflop_ctl;
  end

  // the pin holds its level when stopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      upper_timer_out <= 1'b0;
      upper_run_prev <= 1'b0;
    end
    else
    begin
      upper_timer_out <= next_out;
      upper_run_prev <= upper_run;
    end
  end
endmodule
`default_nettype wire

// File: dtc_pkg.sv
// constants for the dual 8-bit timer control block
// assumes an apb slave with 32-bit data, one word per register
package dtc_pkg;
  localparam int unsigned addr_width = 8;
  // register indices; byte address is four times the index
  localparam logic [5:0] idx_lower_control = 6'h1a;
  localparam logic [5:0] idx_upper_control = 6'h1b;
  localparam logic [5:0] idx_lower_period = 6'h1c;
  localparam logic [5:0] idx_lower_pulse_width = 6'h1d;
  localparam logic [5:0] idx_upper_period = 6'h1f;
  localparam logic [5:0] idx_upper_pulse_width = 6'h2f;
  localparam logic [5:0] idx_int_status = 6'h30;
  localparam logic [5:0] idx_int_mask = 6'h31;
  localparam logic [5:0] idx_count = 6'h32;
  localparam logic [5:0] idx_state = 6'h33;
  localparam logic [5:0] idx_config = 6'h34;
  // control field positions
  localparam int unsigned pos_ff = 7;
  localparam int unsigned pos_clk_hi = 6;
  localparam int unsigned pos_clk_lo = 4;
  localparam int unsigned pos_run = 3;
  localparam int unsigned pos_mode_hi = 2;
  // reset values
  localparam logic [6:0] rst_lower_control = 7'h00;
  localparam logic [7:0] rst_upper_control = 8'h00;
  localparam logic [7:0] rst_period = 8'hff;
  localparam logic [7:0] rst_pulse_width = 8'hff;
  // mode codes
  localparam logic [2:0] mode_timer8 = 3'h0;
  localparam logic [2:0] mode_divider8 = 3'h1;
  localparam logic [2:0] mode_pwm8 = 3'h2;
  localparam logic [2:0] mode_cascade = 3'h3;
  localparam logic [2:0] mode_timer16 = 3'h4;
  localparam logic [2:0] mode_warmup = 3'h5;
  localparam logic [2:0] mode_pwm16 = 3'h6;
  // clock select codes
  localparam logic [2:0] clk_slow_tap = 3'h0;
  localparam logic [2:0] clk_fc_div128 = 3'h1;
  localparam logic [2:0] clk_fc_div32 = 3'h2;
  localparam logic [2:0] clk_fc_div8 = 3'h3;
  localparam logic [2:0] clk_fs = 3'h4;
  localparam logic [2:0] clk_fc_div2 = 3'h5;
  localparam logic [2:0] clk_fc = 3'h6;
  // tick vector positions
  localparam int unsigned tap_fc = 0;
  localparam int unsigned tap_fc_div2 = 1;
  localparam int unsigned tap_fc_div8 = 2;
  localparam int unsigned tap_fc_div32 = 3;
  localparam int unsigned tap_fc_div128 = 4;
  localparam int unsigned tap_fc_div2048 = 5;
  localparam int unsigned tap_fs = 6;
  localparam int unsigned tap_fs_div8 = 7;
  localparam int unsigned tap_count = 8;
  localparam int unsigned fc_div_width = 11;
  localparam int unsigned fs_div_width = 3;
  // interrupt bits
  localparam int unsigned int_lower = 0;
  localparam int unsigned int_upper = 1;
  localparam int unsigned int_count = 2;
endpackage

// File: dtc_tap_if.sv
// carrier for the prescaler tick pulses
// assumes every tick is a one-cycle enable on pclk
`timescale 1ns/100ps
`default_nettype none
interface dtc_tap_if;
  logic [dtc_pkg::tap_count-1:0] tick;
  modport source (output tick);
  modport sink (input tick);
endinterface
`default_nettype wire

// File: dtc_prescaler.sv
// prescaler: fc taps from pclk, fs taps from a synchronised pin
// assumes fs is far slower than pclk
`timescale 1ns/100ps
`default_nettype none
module dtc_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fs_pin,
  dtc_tap_if.source taps
);
  logic [dtc_pkg::fc_div_width-1:0] fc_div;
  logic [dtc_pkg::fs_div_width-1:0] fs_div;
  logic fs_meta;
  logic fs_sync;
  logic fs_prev;
  wire fs_rise = fs_sync & ~fs_prev;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fc_div <= '0;
      fs_div <= '0;
      fs_meta <= 1'b0;
      fs_sync <= 1'b0;
      fs_prev <= 1'b0;
    end
    else
    begin
      fc_div <= fc_div + 1'b1;
      fs_meta <= fs_pin;
      fs_sync <= fs_meta;
      fs_prev <= fs_sync;
      if (fs_rise)
        fs_div <= fs_div + 1'b1;
    end
  end

  // a tap of fc/2^n fires when the low n divider bits are all ones
  assign taps.tick[dtc_pkg::tap_fc] = 1'b1;
  assign taps.tick[dtc_pkg::tap_fc_div2] = &fc_div[0:0];
  assign taps.tick[dtc_pkg::tap_fc_div8] = &fc_div[2:0];
  assign taps.tick[dtc_pkg::tap_fc_div32] = &fc_div[4:0];
  assign taps.tick[dtc_pkg::tap_fc_div128] = &fc_div[6:0];
  assign taps.tick[dtc_pkg::tap_fc_div2048] = &fc_div[10:0];
  assign taps.tick[dtc_pkg::tap_fs] = fs_rise;
  assign taps.tick[dtc_pkg::tap_fs_div8] = fs_rise & (&fs_div);
endmodule
`default_nettype wire

// File: dtc_counter8.sv
// 8-bit up-counter with clear on stop and clear on match
// assumes tick is a one-cycle enable on pclk
`timescale 1ns/100ps
`default_nettype none
module dtc_counter8 #(
  parameter int unsigned width = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic tick,
  input wire logic clear,
  output logic [width-1:0] count,
  output logic carry
);
  // carry feeds the upper counter in cascade
  assign carry = run & tick & ~clear & (&count);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= '0;
    else if (!run)
      count <= '0;
    else if (tick)
      count <= clear ? '0 : count + 1'b1;
  end
endmodule
`default_nettype wire

// File: dtc_timer_assertions.sv
// checker for the dual timer block, sees only the top ports
// assumes apb transfers with one idle cycle between them
`timescale 1ns/100ps
`default_nettype none
module dtc_timer_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fs_pin,
  input wire logic low_speed,
  input wire logic upper_timer_out,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence acc(w, a);
    psel && penable && (pwrite == w) && (paddr == a);
  endsequence
  sequence rd_setup(a);
    psel && !penable && !pwrite && (paddr == a);
  endsequence
  // write, idle, then read of the same word returns it
  property readback(a, m);
    acc(1'b1, a) ##2 rd_setup(a) ##1 acc(1'b0, a) |-> prdata == {24'h0, $past(pwdata[7:0], 3) & m};
  endproperty
  lower_ctrl_readback_a: assert property (readback(8'h68, 8'h7f))
    else $error("lower control readback wrong");
  upper_ctrl_readback_a: assert property (readback(8'h6c, 8'hff))
    else $error("upper control readback wrong");
  upper_pw_readback_a: assert property (readback(8'hbc, 8'hff))
    else $error("upper pulse width readback wrong");
  upper_period_readback_a: assert property (readback(8'h7c, 8'hff))
    else $error("upper period readback wrong");
  stop_clears_a: assert property (acc(1'b1, 8'h68) ##0 (pwdata[3:0] == 4'h0) ##2 rd_setup(8'hc8)
    ##1 acc(1'b0, 8'hc8) |-> prdata[7:0] == 8'h00) else $error("lower count not cleared on stop");
  access_ready_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  misalign_err_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  refused_zero_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  mask_off_a: assert property (acc(1'b1, 8'hc4) ##0 (pwdata[2:0] == 3'h0) |=> !irq)
    else $error("irq high with mask cleared");
endmodule
`default_nettype wire

// File: dtc_timer_tb.sv
// self-checking bench for the dual timer block over apb
// assumes the checker file is compiled before this one
`timescale 1ns/100ps
`default_nettype none
bind dtc_timer dtc_timer_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fs_pin(fs_pin), .low_speed(low_speed), .upper_timer_out(upper_timer_out), .irq(irq));
module dtc_timer_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic fs_pin = 1'b0;
  logic low_speed = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic upper_timer_out;
  logic irq;
  int err_count = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h38e9;
  logic [3:0] fdiv = 4'h0;
  logic [31:0] r;
  logic [31:0] d;
  logic e;
  logic [7:0] regs [4] = '{8'h70, 8'h74, 8'h7c, 8'hbc};
  int n;
  int dv;
  int x;

  dtc_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fs_pin(fs_pin),
    .low_speed(low_speed), .upper_timer_out(upper_timer_out), .irq(irq));

  always #12.5 pclk = ~pclk;
  // slow clock pin, one rising edge every 16 pclk
  always @(posedge pclk)
  begin
    fdiv <= fdiv + 4'h1;
    fs_pin <= fdiv[3];
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // pclk cycles per tick for a select code; 0 means no ticks
  function automatic int divs(input int c, input int ls, input int dvs);
    case (c)
      0: return (ls != 0 || dvs != 0) ? 128 : 2048;
      1: return (ls != 0) ? 0 : 128;
      2: return (ls != 0) ? 0 : 32;
      3: return (ls != 0) ? 0 : 8;
      4: return 16;
      5: return (ls != 0) ? 0 : 2;
      6: return 1;
      default: return 0;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask

  // one transfer; ends one edge after the access so a new setup never collides
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dd, output logic [31:0] rr,
    output logic ee);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (k >= 16)
      err_count++;
    rr = prdata;
    ee = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dd);
    logic [31:0] rr;
    logic ee;
    apb(1'b1, a, dd, rr, ee);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] rr);
    logic ee;
    apb(1'b0, a, 32'h0, rr, ee);
  endtask

  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  task results;
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #2000000;
    err_count++;
    results;
  end

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h68, r);
    chk("lower_ctrl_reset", r, 32'h0);
    rd(8'h6c, r);
    chk("upper_ctrl_reset", r, 32'h0);
    foreach (regs[i])
    begin
      rd(regs[i], r);
      chk("timer_reg_reset", r, 32'hff);
    end
    for (int i = 0; i < 6; i++)
    begin
      foreach (regs[j])
      begin
        d = xs();
        wr(regs[j], d);
        rd(regs[j], r);
        chk("timer_reg_rw", r, {24'h0, d[7:0]});
      end
      d = xs() & 32'hfffffff7;
      wr(8'h68, d);
      rd(8'h68, r);
      chk("lower_ctrl_rw", r, {24'h0, d[7:0] & 8'h7f});
      wr(8'h6c, d);
      rd(8'h6c, r);
      chk("upper_ctrl_rw", r, {24'h0, d[7:0]});
    end
    wr(8'h6c, 32'h0);
    apb(1'b1, 8'h04, 32'h5a, r, e);
    chk("unmapped_wr_err", e, 1);
    apb(1'b0, 8'h69, 32'h0, r, e);
    chk("misaligned_rd_err", e, 1);
    wr(8'h70, 32'hff);
    // every select code at normal speed and codes 0 and 4 at low speed, counted over a fixed window
    for (int ls = 0; ls < 2; ls++)
    begin
      for (int c = 0; c < 8; c++)
      begin
        low_speed <= ls[0];
        // low-speed modes offer the fs taps and fc, not the fc/2^n taps, to an 8-bit timer
        if (ls == 0 || c == 0 || c == 4)
        begin
          dv = xs() & 1;
          wr(8'hd0, dv);
          wr(8'h68, (c << 4) | 8);
          repeat (64) @(posedge pclk);
          rd(8'hc8, r);
          x = divs(c, ls, dv);
          if (x == 0)
            chk("tick_none", r[7:0], 0);
          else
            chk("tick_rate", (r[7:0] + 3 >= 66 / x) && (r[7:0] <= 66 / x + 3), 1);
          // the stop access keeps the select field as it was
          wr(8'h68, c << 4);
          rd(8'hc8, r);
          chk("stop_clear", r[7:0], 0);
        end
      end
    end
    low_speed <= 1'b0;
    for (int m = 1; m < 8; m++)
    begin
      if (m != 3)
      begin
        wr(8'h68, 8'h68 | m);
        repeat (10) @(posedge pclk);
        rd(8'hc8, r);
        chk("reserved_mode_idle", r[7:0], 0);
        wr(8'h68, 8'h60 | m);
      end
    end
    wr(8'h70, 32'h2);
    wr(8'hc0, 32'h3);
    wr(8'hc4, 32'h1);
    wr(8'h68, 32'h68);
    wait_irq(50);
    chk("match_time", n >= 2 && n <= 4, 1);
    wr(8'h68, 32'h60);
    rd(8'hc0, r);
    chk("status_lower", r[1:0], 2'h1);
    wr(8'hc4, 32'h0);
    chk("irq_masked", irq, 0);
    wr(8'hc4, 32'h1);
    chk("irq_unmasked", irq, 1);
    wr(8'hc0, 32'h1);
    chk("irq_cleared", irq, 0);
    rd(8'hc0, r);
    chk("status_cleared", r, 32'h0);
    // cascade: lower run left at 0, upper select reserved and ignored
    wr(8'h70, 32'h3);
    wr(8'h7c, 32'h1);
    wr(8'hc4, 32'h2);
    wr(8'h68, 32'h63);
    wr(8'h6c, 32'hfc);
    wait_irq(600);
    chk("cascade_match", n >= 256 && n <= 262, 1);
    chk("cascade_out", upper_timer_out, 1);
    wr(8'h6c, 32'hf4);
    rd(8'hc8, r);
    chk("cascade_stop", r[15:0], 16'h0);
    wr(8'hc0, 32'h3);
    chk("cascade_irq_clr", irq, 0);
    results;
  end
endmodule
`default_nettype wire
